// ===== common/macu_pkg.sv
`default_nettype none
package macu_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ACC_W = 40;
	localparam int RAM_AW = 10;

	// ------------------------------------------------------------
	// I/O register offsets (low address byte)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_X_START = 8'he0;
	localparam logic [7:0] REG_X_END = 8'he1;
	localparam logic [7:0] REG_X_RELOAD = 8'he2;
	localparam logic [7:0] REG_PAIR_COUNT = 8'he3;
	localparam logic [7:0] REG_Y_START = 8'he4;
	localparam logic [7:0] REG_Y_END = 8'he5;
	localparam logic [7:0] REG_Y_RELOAD = 8'he6;
	localparam logic [7:0] REG_CONTROL = 8'he7;
	localparam logic [7:0] REG_STATUS = 8'he8;
	localparam logic [7:0] REG_ACC_0 = 8'he9;
	localparam logic [7:0] REG_ACC_4 = 8'hed;

	// ------------------------------------------------------------
	// Control fields, status fields, commands
	// ------------------------------------------------------------
	localparam int CTL_LSHIFT_LSB = 0;
	localparam int CTL_RSHIFT_LSB = 3;
	localparam int CTL_FILL_BIT = 6;
	localparam int STAT_STAGE_LSB = 0;
	localparam int STAT_EXEC_LSB = 2;
	localparam logic [7:0] CMD_FORCE_SWAP = 8'h80;
	localparam logic [7:0] LAST_UPPER_MAX = 8'h01;
	localparam logic [5:0] RAM_WINDOW_HI = 6'h37;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

	// Bank status codes
	localparam logic [1:0] ST_EMPTY = 2'h0;
	localparam logic [1:0] ST_READY = 2'h1;
	localparam logic [1:0] ST_IN_PROGRESS = 2'h2;
	localparam logic [1:0] ST_DONE = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b01,
		ENG_RUN  = 2'b10
	} macu_eng_t;

	typedef struct packed {
		logic [7:0]  x_start;
		logic [7:0]  x_end;
		logic [7:0]  x_reload;
		logic [7:0]  y_start;
		logic [7:0]  y_end;
		logic [7:0]  y_reload;
		logic [7:0]  pair_count;
		logic [7:0]  control;
		logic [39:0] acc;
	} macu_bank_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} macu_io_req_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} macu_mem_req_t;
endpackage
`default_nettype wire

// ===== core/macu_acc_shift.sv
`timescale 1ns/1ps
`default_nettype none
module macu_acc_shift (
	// Accumulator and controls
	input  wire logic [39:0] i_acc,
	input  wire logic [7:0]  i_control,
	input  wire logic [2:0]  i_byte_sel,
	input  wire logic [7:0]  i_wdata,
	// Results
	output logic      [39:0] o_acc_wr,
	output logic      [7:0]  o_rd_byte
);
	logic [2:0]         lsh;
	logic [2:0]         rsh;
	logic [5:0]         wpos;
	logic [5:0]         rpos;
	logic [47:0]        ins;
	logic [47:0]        msk;
	logic [39:0]        fmask;
	logic signed [47:0] sx;
	logic signed [47:0] rs;

	// ------------------------------------------------------------
	// Write side: left shift with fill
	// ------------------------------------------------------------
	always_comb begin
		lsh = i_control[macu_pkg::CTL_LSHIFT_LSB +: 3];
		wpos = {i_byte_sel, 3'h0} + {3'h0, lsh};
		ins = {40'h0, i_wdata} << wpos;
		msk = {40'h0, 8'hff} << wpos;
		fmask = (i_byte_sel == 3'h0) ? ~({40{1'b1}} << lsh) : 40'h0;
		o_acc_wr = (i_acc & ~msk[39:0]) | ins[39:0];
		o_acc_wr = (o_acc_wr & ~fmask) | (fmask & {40{i_control[macu_pkg::CTL_FILL_BIT]}});
	end

	// ------------------------------------------------------------
	// Read side: arithmetic right shift
	// ------------------------------------------------------------
	always_comb begin
		rsh = i_control[macu_pkg::CTL_RSHIFT_LSB +: 3];
		rpos = {i_byte_sel, 3'h0} + {3'h0, rsh};
		sx = {{8{i_acc[39]}}, i_acc};
		rs = sx >>> rpos;
		o_rd_byte = rs[7:0];
	end
endmodule // macu_acc_shift
`default_nettype wire

// ===== core/macu_operand_ram.sv
`timescale 1ns/1ps
`default_nettype none
module macu_operand_ram #(
	parameter int AW = 10
) (
	// Clock
	input  wire logic          i_ref_clk,
	// CPU byte port
	input  wire logic          i_cpu_we,
	input  wire logic [AW-1:0] i_cpu_addr,
	input  wire logic [7:0]    i_cpu_wdata,
	output logic      [7:0]    o_cpu_rdata,
	// Engine word port
	input  wire logic [AW-3:0] i_x_index,
	input  wire logic [AW-3:0] i_y_index,
	output logic      [15:0]   o_x_word,
	output logic      [15:0]   o_y_word
);
	logic [7:0] mem_q [0:(1<<AW)-1];

	// CPU write and registered read
	always_ff @(posedge i_ref_clk) begin
		if (i_cpu_we) begin
			mem_q[i_cpu_addr] <= i_cpu_wdata;
		end
		o_cpu_rdata <= mem_q[i_cpu_addr];
	end

	// Engine reads: x in lower half, y in upper half, low byte even
	always_comb begin
		o_x_word = {mem_q[{1'b0, i_x_index, 1'b1}], mem_q[{1'b0, i_x_index, 1'b0}]};
		o_y_word = {mem_q[{1'b1, i_y_index, 1'b1}], mem_q[{1'b1, i_y_index, 1'b0}]};
	end
endmodule // macu_operand_ram
`default_nettype wire

// ===== core/macu_top.sv
// How it works
// - Control bits 2:0 give write-side left shift, 0 to 7.
// - Control bit 6 fills low bits vacated by the left shift.
// - Zero shift: byte k loads accumulator bits 8k+7..8k.
// - Shift n: byte k lands at 8k+7+n..8k+n; overflow past 39 dropped.
// - Control bits 5:3 give read-side right shift, 0 to 7.
// - Right shift fills high bits with copies of bit 39.
// - Shift n: reading byte k returns bits 8k+7+n..8k+n.
// - Block write ending at control or accumulator byte makes staging READY.
// - Staging READY, execution idle: swap banks, start, execution IN PROGRESS.
// - Finished calculation marks execution DONE; software polls for it.
// - Staging EMPTY, execution DONE, write 80h to status: swap.
// - Upper address byte of I/O cycles marks the last block access.
// - Final result byte read empties staging, or swaps if result waits.
// - 1KB operand RAM: CPU byte read/write, engine reads 16-bit words.
// - CPU reaches RAM at DC00h..DFFFh under the RAM upper byte.
// - x operands in lower 512 bytes, y operands in upper 512.
// - Operand low byte at even address, high byte at odd.
// - Index counters start at the start registers.
// - After the end index, the next index comes from reload.
// - Exactly pair-count multiply-accumulate steps, then done.
// - Non-status write while staging DONE makes staging EMPTY.
// - Write to top accumulator byte alone ends a setup.
`timescale 1ns/1ps
`default_nettype none
module macu_top (
	// Clock and reset
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_reset_n,
	// CPU I/O cycles
	input  wire macu_pkg::macu_io_req_t  i_io,
	output logic                         o_io_hit,
	output logic      [7:0]              o_io_rdata,
	// CPU memory cycles
	input  wire macu_pkg::macu_mem_req_t i_mem,
	input  wire logic [7:0]              i_ram_upper,
	output logic                         o_mem_hit,
	output logic      [7:0]              o_mem_rdata,
	// Engine state
	output logic                         o_busy
);
	macu_pkg::macu_bank_t bank_q [0:1];
	macu_pkg::macu_bank_t stage;
	macu_pkg::macu_bank_t exec;
	macu_pkg::macu_eng_t  eng_q;
	logic                 sel_q;
	logic                 eng_bank_q;
	logic [1:0]           stage_st_q;
	logic [1:0]           exec_st_q;
	logic [1:0]           stage_st_d;
	logic [1:0]           exec_st_d;
	logic                 swap_d;
	logic                 start_d;
	logic                 start_q;
	logic [7:0]           lo;
	logic                 io_sel;
	logic                 is_acc;
	logic [2:0]           acc_k;
	logic                 last_access;
	logic                 wr_stage;
	logic                 setup_end;
	logic                 rd_end;
	logic                 force_swap;
	logic [39:0]          acc_wr;
	logic [7:0]           acc_rd;
	logic [7:0]           x_idx_q;
	logic [7:0]           y_idx_q;
	logic [7:0]           cnt_q;
	logic [15:0]          x_word;
	logic [15:0]          y_word;
	logic signed [31:0]   product;
	logic                 eng_step;
	logic                 eng_done;

	// ------------------------------------------------------------
	// I/O address decode
	// ------------------------------------------------------------
	assign lo = i_io.addr[7:0];
	assign io_sel = (lo >= macu_pkg::REG_X_START) && (lo <= macu_pkg::REG_ACC_4);
	assign is_acc = (lo >= macu_pkg::REG_ACC_0) && (lo <= macu_pkg::REG_ACC_4);
	assign acc_k = 3'(lo - macu_pkg::REG_ACC_0);
	assign o_io_hit = io_sel && (i_io.wr || i_io.rd);
	assign stage = bank_q[sel_q];
	assign exec = bank_q[eng_bank_q];

	// Block transfer end from upper address byte
	assign last_access = i_io.addr[15:8] <= macu_pkg::LAST_UPPER_MAX;

	// Events raised by CPU cycles
	assign wr_stage = i_io.wr && io_sel && (lo != macu_pkg::REG_STATUS);
	assign setup_end = i_io.wr && ((last_access && ((lo == macu_pkg::REG_CONTROL) || is_acc))
		|| (lo == macu_pkg::REG_ACC_4));
	assign rd_end = i_io.rd && is_acc && (last_access || (lo == macu_pkg::REG_ACC_4));
	assign force_swap = i_io.wr && (lo == macu_pkg::REG_STATUS)
		&& (i_io.wdata == macu_pkg::CMD_FORCE_SWAP);

	// ------------------------------------------------------------
	// Accumulator byte shifter on the staging bank
	// ------------------------------------------------------------
	macu_acc_shift u_shift (
		.i_acc      (stage.acc),
		.i_control  (stage.control),
		.i_byte_sel (acc_k),
		.i_wdata    (i_io.wdata),
		.o_acc_wr   (acc_wr),
		.o_rd_byte  (acc_rd)
	);

	// ------------------------------------------------------------
	// Operand RAM
	// ------------------------------------------------------------
	assign o_mem_hit = (i_mem.addr[23:16] == i_ram_upper)
		&& (i_mem.addr[15:10] == macu_pkg::RAM_WINDOW_HI);

	macu_operand_ram #(
		.AW (macu_pkg::RAM_AW)
	) u_ram (
		.i_ref_clk   (i_ref_clk),
		.i_cpu_we    (o_mem_hit && i_mem.wr),
		.i_cpu_addr  (i_mem.addr[9:0]),
		.i_cpu_wdata (i_mem.wdata),
		.o_cpu_rdata (o_mem_rdata),
		.i_x_index   (x_idx_q),
		.i_y_index   (y_idx_q),
		.o_x_word    (x_word),
		.o_y_word    (y_word)
	);

	// ------------------------------------------------------------
	// Bank status sequencing
	// ------------------------------------------------------------
	always_comb begin
		stage_st_d = stage_st_q;
		exec_st_d = exec_st_q;
		swap_d = 1'b0;
		start_d = 1'b0;
		if (eng_done) begin
			exec_st_d = macu_pkg::ST_DONE;
		end
		if (wr_stage && (stage_st_d == macu_pkg::ST_DONE)) begin
			stage_st_d = macu_pkg::ST_EMPTY;
		end
		if (setup_end) begin
			stage_st_d = macu_pkg::ST_READY;
		end
		if (rd_end && (stage_st_d == macu_pkg::ST_DONE)) begin
			if (exec_st_d == macu_pkg::ST_DONE) begin
				swap_d = 1'b1;
				exec_st_d = macu_pkg::ST_EMPTY;
			end else begin
				stage_st_d = macu_pkg::ST_EMPTY;
			end
		end
		if (force_swap && (stage_st_d == macu_pkg::ST_EMPTY) && (exec_st_d == macu_pkg::ST_DONE)) begin
			swap_d = 1'b1;
			stage_st_d = macu_pkg::ST_DONE;
			exec_st_d = macu_pkg::ST_EMPTY;
		end
		if ((stage_st_d == macu_pkg::ST_READY) && (exec_st_d != macu_pkg::ST_IN_PROGRESS)) begin
			swap_d = 1'b1;
			start_d = 1'b1;
			stage_st_d = exec_st_d;
			exec_st_d = macu_pkg::ST_IN_PROGRESS;
		end
	end

	// Status and bank selection registers
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage_st_q <= macu_pkg::ST_EMPTY;
			exec_st_q <= macu_pkg::ST_EMPTY;
			sel_q <= 1'b0;
			eng_bank_q <= 1'b1;
			start_q <= 1'b0;
		end else begin
			stage_st_q <= stage_st_d;
			exec_st_q <= exec_st_d;
			start_q <= start_d;
			if (swap_d) begin
				sel_q <= ~sel_q;
				eng_bank_q <= sel_q;
			end
		end
	end

	assign o_busy = exec_st_q == macu_pkg::ST_IN_PROGRESS;

	// ------------------------------------------------------------
	// Bank registers: CPU writes to staging, engine to execution
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int b = 0; b < 2; b++) begin
				bank_q[b].x_start <= macu_pkg::INDEX_RESET;
				bank_q[b].x_end <= macu_pkg::INDEX_RESET;
				bank_q[b].x_reload <= macu_pkg::INDEX_RESET;
				bank_q[b].y_start <= macu_pkg::INDEX_RESET;
				bank_q[b].y_end <= macu_pkg::INDEX_RESET;
				bank_q[b].y_reload <= macu_pkg::INDEX_RESET;
				bank_q[b].pair_count <= macu_pkg::INDEX_RESET;
				bank_q[b].control <= macu_pkg::CTL_RESET;
				bank_q[b].acc <= macu_pkg::ACC_RESET;
			end
		end else begin
			if (eng_step) begin
				bank_q[eng_bank_q].acc <= exec.acc + {{8{product[31]}}, product};
			end
			if (wr_stage) begin
				case (lo)
					macu_pkg::REG_X_START: bank_q[sel_q].x_start <= i_io.wdata;
					macu_pkg::REG_X_END: bank_q[sel_q].x_end <= i_io.wdata;
					macu_pkg::REG_X_RELOAD: bank_q[sel_q].x_reload <= i_io.wdata;
					macu_pkg::REG_PAIR_COUNT: bank_q[sel_q].pair_count <= i_io.wdata;
					macu_pkg::REG_Y_START: bank_q[sel_q].y_start <= i_io.wdata;
					macu_pkg::REG_Y_END: bank_q[sel_q].y_end <= i_io.wdata;
					macu_pkg::REG_Y_RELOAD: bank_q[sel_q].y_reload <= i_io.wdata;
					macu_pkg::REG_CONTROL: bank_q[sel_q].control <= i_io.wdata;
					default: begin
						if (is_acc) begin
							bank_q[sel_q].acc <= acc_wr;
						end
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Register read data
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_io_rdata <= 8'h00;
		end else if (i_io.rd) begin
			case (lo)
				macu_pkg::REG_X_START: o_io_rdata <= stage.x_start;
				macu_pkg::REG_X_END: o_io_rdata <= stage.x_end;
				macu_pkg::REG_X_RELOAD: o_io_rdata <= stage.x_reload;
				macu_pkg::REG_PAIR_COUNT: o_io_rdata <= stage.pair_count;
				macu_pkg::REG_Y_START: o_io_rdata <= stage.y_start;
				macu_pkg::REG_Y_END: o_io_rdata <= stage.y_end;
				macu_pkg::REG_Y_RELOAD: o_io_rdata <= stage.y_reload;
				macu_pkg::REG_CONTROL: o_io_rdata <= stage.control;
				macu_pkg::REG_STATUS: o_io_rdata <= {4'h0, exec_st_q, stage_st_q};
				default: o_io_rdata <= is_acc ? acc_rd : 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Multiply-accumulate engine
	// ------------------------------------------------------------
	assign eng_step = (eng_q == macu_pkg::ENG_RUN) && (cnt_q != 8'h00);
	assign eng_done = (eng_q == macu_pkg::ENG_RUN) && (cnt_q == 8'h00);
	assign product = $signed(x_word) * $signed(y_word);

	// Sequencer and circular index counters
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			eng_q <= macu_pkg::ENG_IDLE;
			cnt_q <= 8'h00;
			x_idx_q <= macu_pkg::INDEX_RESET;
			y_idx_q <= macu_pkg::INDEX_RESET;
		end else begin
			case (eng_q)
				macu_pkg::ENG_IDLE: begin
					if (start_q) begin
						eng_q <= macu_pkg::ENG_RUN;
						cnt_q <= exec.pair_count;
						x_idx_q <= exec.x_start;
						y_idx_q <= exec.y_start;
					end
				end
				macu_pkg::ENG_RUN: begin
					if (eng_step) begin
						cnt_q <= cnt_q - 8'h01;
						x_idx_q <= (x_idx_q == exec.x_end) ? exec.x_reload : x_idx_q + 8'h01;
						y_idx_q <= (y_idx_q == exec.y_end) ? exec.y_reload : y_idx_q + 8'h01;
					end else begin
						eng_q <= macu_pkg::ENG_IDLE;
					end
				end
				default: eng_q <= macu_pkg::ENG_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	ready_mark_a: assert property (
		setup_end && exec_st_q == macu_pkg::ST_IN_PROGRESS && !eng_done |=> stage_st_q == macu_pkg::ST_READY)
		else $error("setup end did not mark staging ready");

	auto_start_a: assert property (
		setup_end && exec_st_q != macu_pkg::ST_IN_PROGRESS
		|=> exec_st_q == macu_pkg::ST_IN_PROGRESS ##1 eng_q == macu_pkg::ENG_RUN)
		else $error("ready bank was not started");

	done_mark_a: assert property (
		eng_done && stage_st_q != macu_pkg::ST_READY && !setup_end && !rd_end && !force_swap
		|=> exec_st_q == macu_pkg::ST_DONE)
		else $error("finished calculation not marked done");

	force_swap_a: assert property (
		force_swap && stage_st_q == macu_pkg::ST_EMPTY && exec_st_q == macu_pkg::ST_DONE && !eng_done
		|=> stage_st_q == macu_pkg::ST_DONE && exec_st_q == macu_pkg::ST_EMPTY && sel_q != $past(sel_q))
		else $error("status command did not swap banks");

	read_swap_a: assert property (
		rd_end && stage_st_q == macu_pkg::ST_DONE && exec_st_q == macu_pkg::ST_DONE
		|=> stage_st_q == macu_pkg::ST_DONE && exec_st_q == macu_pkg::ST_EMPTY)
		else $error("final read did not retrieve waiting result");

	read_empty_a: assert property (
		rd_end && stage_st_q == macu_pkg::ST_DONE && exec_st_q != macu_pkg::ST_DONE && !eng_done
		|=> stage_st_q == macu_pkg::ST_EMPTY)
		else $error("final read did not empty staging");

	stage_clear_a: assert property (
		wr_stage && !setup_end && stage_st_q == macu_pkg::ST_DONE |=> stage_st_q == macu_pkg::ST_EMPTY)
		else $error("write did not discard staged result");

	index_load_a: assert property (
		eng_q == macu_pkg::ENG_IDLE && start_q |=> x_idx_q == $past(exec.x_start) && cnt_q == $past(exec.pair_count))
		else $error("index counters not loaded from start");

	index_wrap_a: assert property (
		eng_step && x_idx_q == exec.x_end |=> x_idx_q == $past(exec.x_reload))
		else $error("x index did not take reload value");

	y_wrap_a: assert property (
		eng_step && y_idx_q == exec.y_end |=> y_idx_q == $past(exec.y_reload))
		else $error("y index did not take reload value");

	step_count_a: assert property (
		eng_step && cnt_q == 8'h01 |=> eng_done ##1 eng_q == macu_pkg::ENG_IDLE || start_q)
		else $error("engine ran a wrong number of steps");
endmodule // macu_top
`default_nettype wire

// ===== dv/macu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module macu_cpu_model (
	// Clock
	input  wire logic                    i_ref_clk,
	// Cycles towards the unit
	output var  macu_pkg::macu_io_req_t  o_io,
	output var  macu_pkg::macu_mem_req_t o_mem,
	output logic      [7:0]              o_ram_upper,
	// Answers from the unit
	input  wire logic [7:0]              i_io_rdata,
	input  wire logic [7:0]              i_mem_rdata
);
	// ------------------------------------------------------------
	// Idle bus and RAM upper-address register
	// ------------------------------------------------------------
	initial begin
		o_io = '0;
		o_mem = '0;
		o_ram_upper = 8'h12;
	end

	// ------------------------------------------------------------
	// One byte cycle, request held across one sampling edge
	// ------------------------------------------------------------
	task automatic cyc(input logic mem, input logic wr, input logic [23:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(posedge i_ref_clk);
		#1;
		if (mem) begin
			o_mem.wr = wr;
			o_mem.rd = ~wr;
			o_mem.addr = a;
			o_mem.wdata = d;
		end else begin
			o_io.wr = wr;
			o_io.rd = ~wr;
			o_io.addr = a[15:0];
			o_io.wdata = d;
		end
		@(posedge i_ref_clk);
		#1;
		q = mem ? i_mem_rdata : i_io_rdata;
		// Released lines show no stale value
		o_io = '{wr: 1'b0, rd: 1'b0, addr: ~o_io.addr, wdata: ~o_io.wdata};
		o_mem = '{wr: 1'b0, rd: 1'b0, addr: ~o_mem.addr, wdata: ~o_mem.wdata};
	endtask
endmodule // macu_cpu_model
`default_nettype wire

// ===== dv/macu_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(NM, EXP, GOT) begin check_count++; if ((GOT) !== (EXP)) begin errors++; \
	$display("[ERR] %s expected %h seen %h", NM, EXP, GOT); end end
module macu_top_tb_top;
	logic                    i_ref_clk;
	logic                    i_reset_n;
	macu_pkg::macu_io_req_t  io;
	macu_pkg::macu_mem_req_t mem;
	logic [7:0]              ram_upper;
	logic [7:0]              io_rdata;
	logic [7:0]              mem_rdata;
	logic                    busy;
	logic                    busy_seen;
	logic                    io_hit;
	logic                    mem_hit;
	logic                    io_hit_q;
	logic                    mem_hit_q;
	logic [39:0]             acc_exp;
	logic [7:0]              q;
	int                      errors;
	int                      check_count;

	// ------------------------------------------------------------
	// Design, CPU model, clock, reset
	// ------------------------------------------------------------
	macu_top u_macu_top (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_io(io), .o_io_hit(io_hit),
		.o_io_rdata(io_rdata), .i_mem(mem), .i_ram_upper(ram_upper), .o_mem_hit(mem_hit),
		.o_mem_rdata(mem_rdata), .o_busy(busy));
	macu_cpu_model u_macu_cpu_model (.i_ref_clk(i_ref_clk), .o_io(io), .o_mem(mem),
		.o_ram_upper(ram_upper), .i_io_rdata(io_rdata), .i_mem_rdata(mem_rdata));

	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end

	// Sticky record of the engine running
	always @(posedge i_ref_clk) begin
		if (busy === 1'b1) busy_seen <= 1'b1;
	end

	// Hit flags taken at the edge that samples each request
	always @(posedge i_ref_clk) begin
		if (io.wr || io.rd) io_hit_q <= io_hit;
		if (mem.wr || mem.rd) mem_hit_q <= mem_hit;
	end

	// ------------------------------------------------------------
	// Bus helpers
	// ------------------------------------------------------------
	task automatic w(input logic [15:0] a, input logic [7:0] d);
		u_macu_cpu_model.cyc(1'b0, 1'b1, {8'h00, a}, d, q);
	endtask

	task automatic r(input logic [15:0] a);
		u_macu_cpu_model.cyc(1'b0, 1'b0, {8'h00, a}, 8'h00, q);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Software polls status until the expected code shows
	task automatic poll(input logic [7:0] exp);
		for (int i = 0; i < 64; i++) begin
			r(16'h00e8);
			if (q === exp) return;
		end
		`CHK("status wait", exp, q)
		tally_and_finish();
	endtask

	// Pull the finished result into the staging bank
	task automatic swap_out();
		w(16'h00e8, macu_pkg::CMD_FORCE_SWAP);
		r(16'h00e8);
		`CHK("status after swap", 8'h03, q)
	endtask

	task automatic chk_acc(input logic [39:0] a, input logic [2:0] rs);
		logic signed [39:0] sh;
		sh = $signed(a) >>> rs;
		for (int k = 0; k < 5; k++) begin
			r({(k == 4) ? 8'h00 : 8'h02, 8'(macu_pkg::REG_ACC_0 + k)});
			`CHK("acc byte", sh[8*k +: 8], q)
		end
		r(16'h00e8);
		`CHK("status after read", 8'h00, q)
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		r(16'h00e8);
		`CHK("status reset", 8'h00, q)
		r(16'h00e7);
		`CHK("control reset", macu_pkg::CTL_RESET, q)
		r(16'h00ef);
		`CHK("unmapped read", 8'h00, q)
		`CHK("io hit unmapped", 1'b0, io_hit_q)
		w(16'h02e0, 8'h55);
		r(16'h00e0);
		`CHK("start index rw", 8'h55, q)
		`CHK("io hit mapped", 1'b1, io_hit_q)
	endtask

	// Shifted loads and reads for several control settings
	task automatic t_shift();
		logic [7:0] ctls[3] = '{8'h5b, 8'h00, 8'h2f};
		logic [7:0] wb[5] = '{8'h3c, 8'ha5, 8'h0f, 8'hc3, 8'h9d};
		logic [2:0] ls;
		for (int i = 0; i < 3; i++) begin
			ls = ctls[i][2:0];
			w(16'h02e3, 8'h00);
			w(16'h02e7, ctls[i]);
			for (int k = 0; k < 4; k++) w({8'h02, 8'(macu_pkg::REG_ACC_0 + k)}, wb[k]);
			w({8'h02, macu_pkg::REG_ACC_4}, wb[4]);
			acc_exp = {wb[4], wb[3], wb[2], wb[1], wb[0]} << ls;
			if (ctls[i][6]) acc_exp = acc_exp | ((40'h1 << ls) - 40'h1);
			poll(8'h0c);
			swap_out();
			chk_acc(acc_exp, ctls[i][5:3]);
		end
	endtask

	// Circular indexing over RAM operands
	task automatic t_mac();
		logic [15:0] xw[4] = '{16'h0003, 16'hfffe, 16'h0100, 16'h7fff};
		logic [15:0] yw[4] = '{16'h0002, 16'h0005, 16'hffff, 16'h0010};
		logic [7:0] regs[7] = '{8'h01, 8'h02, 8'h00, 8'h04, 8'h00, 8'h09, 8'h00};
		int ix;
		// Two's complement words, low byte even, loaded before setup
		for (int n = 0; n < 4; n++) begin
			u_macu_cpu_model.cyc(1'b1, 1'b1, {8'h12, 16'hdc00 + 16'(2*n)}, xw[n][7:0], q);
			u_macu_cpu_model.cyc(1'b1, 1'b1, {8'h12, 16'hdc01 + 16'(2*n)}, xw[n][15:8], q);
			u_macu_cpu_model.cyc(1'b1, 1'b1, {8'h12, 16'hde00 + 16'(2*n)}, yw[n][7:0], q);
			u_macu_cpu_model.cyc(1'b1, 1'b1, {8'h12, 16'hde01 + 16'(2*n)}, yw[n][15:8], q);
		end
		u_macu_cpu_model.cyc(1'b1, 1'b1, {8'h13, 16'hdc00}, 8'hee, q);
		`CHK("ram miss", 1'b0, mem_hit_q)
		u_macu_cpu_model.cyc(1'b1, 1'b0, {8'h12, 16'hdc00}, 8'h00, q);
		`CHK("ram x low", xw[0][7:0], q)
		`CHK("ram hit", 1'b1, mem_hit_q)
		u_macu_cpu_model.cyc(1'b1, 1'b0, {8'h12, 16'hde07}, 8'h00, q);
		`CHK("ram y high", yw[3][15:8], q)
		for (int i = 0; i < 7; i++) w({8'h02, 8'(macu_pkg::REG_X_START + i)}, regs[i]);
		w(16'h02e7, 8'h00);
		r(16'h00e8);
		`CHK("no block end", 8'h00, q)
		busy_seen = 1'b0;
		w(16'h01e7, 8'h00);
		ix = 1;
		for (int s = 0; s < 4; s++) begin
			acc_exp = acc_exp + 40'($signed(xw[ix]) * $signed(yw[s]));
			ix = (ix == 2) ? 0 : ix + 1;
		end
		poll(8'h0c);
		`CHK("engine busy", 1'b1, busy_seen)
		swap_out();
		chk_acc(acc_exp, 3'h0);
	endtask

	// Refused swaps and a discarded result
	task automatic t_refuse();
		w(16'h00e8, macu_pkg::CMD_FORCE_SWAP);
		r(16'h00e8);
		`CHK("swap idle", 8'h00, q)
		w(16'h02e3, 8'h00);
		w({8'h00, macu_pkg::REG_ACC_4}, 8'h11);
		poll(8'h0c);
		w(16'h00e8, 8'h81);
		r(16'h00e8);
		`CHK("bad command", 8'h0c, q)
		swap_out();
		w(16'h02e0, 8'h07);
		r(16'h00e8);
		`CHK("result dropped", 8'h00, q)
	endtask

	// Second calculation queued behind a running one, then both retrieved
	task automatic t_queue();
		w(16'h02e0, 8'h01);
		w(16'h02e5, 8'h03);
		w(16'h02e3, 8'h20);
		w({8'h00, macu_pkg::REG_ACC_4}, 8'h00);
		w(16'h01e7, 8'h00);
		r(16'h00e8);
		`CHK("queued ready", 8'h09, q)
		poll(8'h0f);
		r({8'h02, macu_pkg::REG_ACC_4});
		r(16'h00e8);
		`CHK("read swap", 8'h03, q)
		r({8'h02, macu_pkg::REG_ACC_4});
		r(16'h00e8);
		`CHK("read empty", 8'h00, q)
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		errors = 0;
		check_count = 0;
		busy_seen = 1'b0;
		acc_exp = '0;
		i_reset_n = 1'b0;
		repeat (3) @(posedge i_ref_clk);
		#1;
		i_reset_n = 1'b1;
		t_reset();
		t_shift();
		t_mac();
		t_refuse();
		t_queue();
		tally_and_finish();
	end
endmodule // macu_top_tb_top
`default_nettype wire
